/* hw/pci_pm_capability_regs.sv */
// configuration registers: capability pointer, power-management
// capability head and the port wake mask of the enhanced function.
// assumes the host side presents one request pulse at a time on ref_clk.
// assumes PM_BASE is dword aligned and clear of the mask dword.
// assumes a request held through the answer cycle is not taken twice.
//
// Notes on behaviour
// - wake mask 16-bit rw, resets to 0007h
// - mask is stored and read back only
// - pm structure sits at capability pointer offset
// - identifier byte read-only, returns 01h
// - next pointer 00h ohci, E4h ehci
// - capabilities word field layout as declared
// - capabilities fixed bits, function-dependent 13,11,10
// - pme support bit per power state
`timescale 1ns/1ns
module pci_pm_capability_regs
  import pm_cap_pkg::*;
#(
  parameter logic       IS_EHCI = 1'b1,
  parameter logic [7:0] PM_BASE = 8'hDC
) (
  input  wire logic     ref_clk,
  input  wire logic     rst,
  input  wire cfg_req_t cfg_req,
  output cfg_rsp_t      cfg_rsp
);

  // ***********************************************************************
  // fixed capability contents
  // ***********************************************************************
  localparam logic [7:0] NEXT_PTR_VALUE =
    IS_EHCI ? NEXT_PTR_EHCI : NEXT_PTR_OHCI;

  localparam power_caps_t CAPS_VALUE = '{
    pme_state_support:  IS_EHCI ? PME_SUPPORT_EHCI
                                : PME_SUPPORT_OHCI,
    state_d2_supported: IS_EHCI,
    state_d1_supported: 1'b1,
    aux_current:        AUX_CURRENT_VAL,
    device_init_needed: 1'b0,
    reserved_bit:       1'b0,
    pme_needs_clock:    1'b0,
    pm_spec_version:    PM_VERSION_VAL
  };

  localparam logic [15:0] CAPS_WORD = CAPS_VALUE;

  // byte addresses of the pm structure and the mask high byte
  localparam logic [7:0] PM_ID_ADDR   = 8'(PM_BASE + PM_ID_REL);
  localparam logic [7:0] PM_NEXT_ADDR = 8'(PM_BASE + PM_NEXT_REL);
  localparam logic [7:0] PM_CAPS_ADDR = 8'(PM_BASE + PM_CAPS_REL);
  localparam logic [7:0] PM_CAPS_HI   = 8'(PM_CAPS_ADDR + 8'h01);
  localparam logic [7:0] WAKE_HI_ADDR = 8'(PORT_WAKE_OFFSET + 8'h01);

  // ***********************************************************************
  // state
  // ***********************************************************************
  typedef struct packed {
    cfg_phase_t  phase;
    logic        ack;
    logic [31:0] rdata;
  } top_state_t;

  // one request as seen in the idle phase
  typedef struct packed {
    logic                       taken;
    logic                       is_read;
    logic                       is_write;
    logic                       wake_hit;
    logic [PORT_WAKE_BYTES-1:0] wake_be;
    logic [15:0]                wake_data;
  } req_decode_t;

  top_state_t state_reg;
  top_state_t state_next;

  req_decode_t                dec;
  logic [15:0]                wake_mask;
  logic                       wake_wr_en;
  logic [31:0]                read_word;
  logic [31:0]                answer_word;

  // ***********************************************************************
  // byte read decode
  // ***********************************************************************
  function automatic logic [7:0] cfg_byte(input logic [7:0] a,
                                          input logic [15:0] mask);
    logic [7:0] b;
    b = ZERO_BYTE;
    case (a)
      CAP_PTR_OFFSET: begin
        b = PM_BASE;
      end
      PM_ID_ADDR: begin
        b = CAPABILITY_IDENTIFIER_VALUE;
      end
      PM_NEXT_ADDR: begin
        b = NEXT_PTR_VALUE;
      end
      PM_CAPS_ADDR: begin
        b = CAPS_WORD[7:0];
      end
      PM_CAPS_HI: begin
        b = CAPS_WORD[15:8];
      end
      PORT_WAKE_OFFSET: begin
        if (IS_EHCI) begin
          b = mask[7:0];
        end
      end
      WAKE_HI_ADDR: begin
        if (IS_EHCI) begin
          b = mask[15:8];
        end
      end
      default: begin
        b = ZERO_BYTE;
      end
    endcase
    return b;
  endfunction

  // ***********************************************************************
  // request decode
  // ***********************************************************************
  always_comb begin
    dec           = '0;
    dec.taken     = (state_reg.phase == PH_IDLE) &&
                    (cfg_req.rd || cfg_req.wr);
    // rd with wr together counts as a read
    dec.is_read   = dec.taken && cfg_req.rd;
    dec.is_write  = dec.taken && cfg_req.wr && !cfg_req.rd;
    dec.wake_hit  = IS_EHCI &&
                    (cfg_req.addr[7:2] == PORT_WAKE_OFFSET[7:2]);
    dec.wake_be   = cfg_req.be[PORT_WAKE_LANE +: PORT_WAKE_BYTES];
    dec.wake_data = cfg_req.wdata[PORT_WAKE_LANE*8 +: 16];
  end

  // only the mask takes writes; other fields silently keep their value
  assign wake_wr_en = dec.is_write && dec.wake_hit;

  // ***********************************************************************
  // read data
  // ***********************************************************************
  always_comb begin
    read_word = '0;
    for (int i = 0; i < 4; i++) begin
      read_word[i*8 +: 8] = cfg_byte({cfg_req.addr[7:2], 2'(i)},
                                     wake_mask);
    end
  end

  // a write answers with zero data
  always_comb begin
    answer_word = '0;
    if (dec.is_read) begin
      answer_word = read_word;
    end
  end

  // ***********************************************************************
  // answer phase
  // ***********************************************************************
  always_comb begin
    state_next     = state_reg;
    state_next.ack = 1'b0;
    case (state_reg.phase)
      PH_IDLE: begin
        if (dec.taken) begin
          state_next.phase = PH_ANSWER;
          state_next.ack   = 1'b1;
          state_next.rdata = answer_word;
        end
      end
      PH_ANSWER: begin
        state_next.phase = PH_IDLE;
      end
      default: begin
        state_next.phase = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg.phase <= PH_IDLE;
      state_reg.ack   <= 1'b0;
      state_reg.rdata <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ***********************************************************************
  // port wake mask storage, no influence on controller operation
  // ***********************************************************************
  byte_lane_reg #(
    .BYTES       (PORT_WAKE_BYTES),
    .RESET_VALUE (PORT_WAKE_RESET)
  ) u_wake_mask (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wake_wr_en),
    .be      (dec.wake_be),
    .wdata   (dec.wake_data),
    .value   (wake_mask)
  );

  // ***********************************************************************
  // outputs, straight from the state register
  // ***********************************************************************
  assign cfg_rsp.ack   = state_reg.ack;
  assign cfg_rsp.rdata = state_reg.rdata;

endmodule

/* shared/pm_cap_pkg.sv */
// constants, field layouts and carrier types of the power-management
// capability registers and the port wake mask.
// assumes the configuration port presents dword accesses with byte enables.
package pm_cap_pkg;

  // ***********************************************************************
  // configuration space offsets
  // ***********************************************************************
  localparam logic [7:0] CAP_PTR_OFFSET   = 8'h34;
  localparam logic [7:0] PORT_WAKE_OFFSET = 8'h62;
  localparam logic [7:0] PM_ID_REL        = 8'h00;
  localparam logic [7:0] PM_NEXT_REL      = 8'h01;
  localparam logic [7:0] PM_CAPS_REL      = 8'h02;
  localparam int         PORT_WAKE_LANE   = int'(PORT_WAKE_OFFSET[1:0]);
  localparam int         PORT_WAKE_BYTES  = 2;

  // ***********************************************************************
  // fixed and reset values
  // ***********************************************************************
  localparam logic [15:0] PORT_WAKE_RESET = 16'h0007;
  localparam logic [7:0]  CAPABILITY_IDENTIFIER_VALUE    = 8'h01;
  localparam logic [7:0]  NEXT_PTR_OHCI   = 8'h00;
  localparam logic [7:0]  NEXT_PTR_EHCI   = 8'hE4;
  localparam logic [7:0]  ZERO_BYTE       = 8'h00;

  // pme support bits: [0] D0, [1] D1, [2] D2, [3] D3hot, [4] D3cold
  localparam logic [4:0]  PME_SUPPORT_OHCI = 5'h1A;
  localparam logic [4:0]  PME_SUPPORT_EHCI = 5'h1F;
  localparam logic [2:0]  AUX_CURRENT_VAL  = 3'h2;
  localparam logic [2:0]  PM_VERSION_VAL   = 3'h2;

  // ***********************************************************************
  // field layouts and carriers
  // ***********************************************************************
  typedef struct packed {
    logic [4:0] pme_state_support;
    logic       state_d2_supported;
    logic       state_d1_supported;
    logic [2:0] aux_current;
    logic       device_init_needed;
    logic       reserved_bit;
    logic       pme_needs_clock;
    logic [2:0] pm_spec_version;
  } power_caps_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } cfg_rsp_t;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b01,
    PH_ANSWER = 2'b10
  } cfg_phase_t;

endpackage

/* hw/byte_lane_reg.sv */
// a read/write register written byte by byte under byte enables.
// assumes wr_en is a single-cycle strobe in the ref_clk domain.
`timescale 1ns/1ns
module byte_lane_reg
  import pm_cap_pkg::*;
#(
  parameter int                 BYTES       = 2,
  parameter logic [BYTES*8-1:0] RESET_VALUE = '0
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 wr_en,
  input  wire logic [BYTES-1:0]     be,
  input  wire logic [BYTES*8-1:0]   wdata,
  output logic      [BYTES*8-1:0]   value
);

  logic [BYTES*8-1:0] value_reg;
  logic [BYTES*8-1:0] value_next;

  always_comb begin
    value_next = value_reg;
    for (int i = 0; i < BYTES; i++) begin
      if (wr_en && be[i]) begin
        value_next[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      value_reg <= RESET_VALUE;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule

/* verif/pm_cap_sva.sv */
// assertions on the configuration port of the pm capability registers
// assumes a dword-aligned PM_BASE and one request at a time
`timescale 1ns/1ns
module pm_cap_sva
  import pm_cap_pkg::*;
#(
  parameter logic       IS_EHCI = 1'b1,
  parameter logic [7:0] PM_BASE = 8'hDC
) (
  input wire logic     ref_clk,
  input wire logic     rst,
  input wire cfg_req_t cfg_req,
  input wire cfg_rsp_t cfg_rsp
);
  localparam logic [15:0] CAPS = IS_EHCI ? 16'hFE82 : 16'hD282;
  localparam logic [7:0]  NXT  = IS_EHCI ? 8'hE4 : 8'h00;
  logic        took_reg;
  logic [15:0] mask_reg;
  logic        take;
  assign take = (cfg_req.rd | cfg_req.wr) & ~took_reg;
  // shadow of the wake mask
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      took_reg <= 1'b0;
      mask_reg <= 16'h0007;
    end else begin
      took_reg <= take;
      if (take & cfg_req.wr & ~cfg_req.rd & IS_EHCI
          & (cfg_req.addr[7:2] == 6'h18)) begin
        if (cfg_req.be[2]) mask_reg[7:0] <= cfg_req.wdata[23:16];
        if (cfg_req.be[3]) mask_reg[15:8] <= cfg_req.wdata[31:24];
      end
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence s_take;
    take;
  endsequence
  sequence s_rd(logic [5:0] dw);
    take && cfg_req.rd && cfg_req.addr[7:2] == dw;
  endsequence
  chk_ack_pulse: assert property (
    s_take |=> cfg_rsp.ack ##1 !cfg_rsp.ack)
    else $error("ack not one pulse");
  chk_ack_cause: assert property (cfg_rsp.ack |-> $past(take))
    else $error("ack without request");
  chk_busy_refused: assert property (
    (s_take ##1 (cfg_req.rd | cfg_req.wr)) |=> !cfg_rsp.ack)
    else $error("request taken while busy");
  chk_id_read: assert property (
    s_rd(PM_BASE[7:2]) |=> cfg_rsp.rdata == {CAPS, NXT, 8'h01})
    else $error("pm head wrong");
  chk_cap_ptr: assert property (s_rd(6'h0D) |=>
    cfg_rsp.rdata == {24'h0, PM_BASE}) else $error("pointer wrong");
  chk_mask_read: assert property (
    s_rd(6'h18) |=> cfg_rsp.rdata ==
    (IS_EHCI ? {mask_reg, 16'h0} : 32'h0)) else $error("mask wrong");
  chk_write_zero: assert property (take && !cfg_req.rd |=>
    cfg_rsp.rdata == 32'h0) else $error("write data not zero");
  chk_rdata_hold: assert property (!take |=> $stable(cfg_rsp.rdata))
    else $error("rdata moved");
endmodule
bind pci_pm_capability_regs pm_cap_sva #(.IS_EHCI(IS_EHCI),
  .PM_BASE(PM_BASE)) u_sva (.ref_clk(ref_clk), .rst(rst),
  .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));

/* verif/cfg_host.sv */
// host issuing configuration cycles to two functions at once
// assumes the one-cycle ack handshake of the register port
`timescale 1ns/1ns
module cfg_host
  import pm_cap_pkg::*;
(
  input  wire logic     ref_clk,
  input  wire cfg_rsp_t rsp_a,
  input  wire cfg_rsp_t rsp_b,
  output cfg_req_t      cfg_req
);
  initial cfg_req = '0;
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [3:0] b, input logic [31:0] d,
                      output logic [31:0] ra, output logic [31:0] rb,
                      output logic ok);
    int n;
    n = 0;
    @(posedge ref_clk);
    #1 cfg_req = '{rd:~w, wr:w, addr:a, be:b, wdata:d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (rsp_a.ack !== 1'b1 && n < 8);
    ok = (rsp_a.ack === 1'b1) && (rsp_b.ack === 1'b1);
    ra = rsp_a.rdata;
    rb = rsp_b.rdata;
    // released lines show no stale value
    #1 cfg_req = '{rd:1'b0, wr:1'b0, addr:~a, be:~b, wdata:~d};
  endtask
endmodule

/* verif/tb_top.sv */
// testbench: enhanced and open functions side by side
// assumes cfg_host and the bound checker
`timescale 1ns/1ns
module tb_top
  import pm_cap_pkg::*;
;
  typedef struct packed {
    logic w; logic [7:0] a; logic [3:0] b;
    logic [31:0] d; logic [31:0] xe; logic [31:0] xo;
  } row_t;
  row_t rows[10] = '{
    '{1'b0, 8'h34, 4'h0, 32'h0, 32'h000000DC, 32'h000000DC},
    '{1'b0, 8'hDC, 4'h0, 32'h0, 32'hFE82E401, 32'hD2820001},
    '{1'b0, 8'h62, 4'h0, 32'h0, 32'h00070000, 32'h0},
    '{1'b1, 8'h60, 4'hC, 32'h12340000, 32'h0, 32'h0},
    '{1'b0, 8'h60, 4'h0, 32'h0, 32'h12340000, 32'h0},
    '{1'b1, 8'h63, 4'h8, 32'hAB000000, 32'h0, 32'h0},
    '{1'b0, 8'h60, 4'h0, 32'h0, 32'hAB340000, 32'h0},
    '{1'b1, 8'hDC, 4'hF, 32'hFFFFFFFF, 32'h0, 32'h0},
    '{1'b0, 8'hDC, 4'h0, 32'h0, 32'hFE82E401, 32'hD2820001},
    '{1'b0, 8'hF0, 4'h0, 32'h0, 32'h0, 32'h0}};
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  cfg_req_t    req;
  cfg_rsp_t    rsp_e, rsp_o;
  logic [31:0] ra, rb;
  logic        ok;
  int          n_errors = 0, n_tests = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  pci_pm_capability_regs #(.IS_EHCI(1'b1)) u_dut (.ref_clk(ref_clk),
    .rst(rst), .cfg_req(req), .cfg_rsp(rsp_e));
  pci_pm_capability_regs #(.IS_EHCI(1'b0)) u_dut_ohci (.ref_clk(ref_clk),
    .rst(rst), .cfg_req(req), .cfg_rsp(rsp_o));
  cfg_host u_host (.ref_clk(ref_clk), .rsp_a(rsp_e), .rsp_b(rsp_o),
    .cfg_req(req));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 rst = 1'b0;
    foreach (rows[i]) begin
      // row i: one transfer, ack of both functions and both answer words checked
      u_host.xfer(rows[i].w, rows[i].a, rows[i].b, rows[i].d,
                  ra, rb, ok);
      check({31'h0, ok}, 32'h1);
      check(ra, rows[i].xe);
      check(rb, rows[i].xo);
    end
    $display("register rows done");
    @(posedge ref_clk);
    #1 rst = 1'b1;
    #2 check({rsp_e.ack, rsp_e.rdata[30:0]}, 32'h0);
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    u_host.xfer(1'b0, 8'h60, 4'h0, 32'h0, ra, rb, ok);
    check(ra, 32'h00070000);
    $display("reset test done");
    end_sim();
  end
endmodule
